// file: fes_pkg.sv
// Constants shared by the flash command sequencer host controller
package fes_pkg;
	// Clock rate and flash bus timing (least times, rounded up to cycles)
	localparam int CLK_MHZ       = 250;
	localparam int T_WE_LOW_NS   = 50;
	localparam int T_ACC_NS      = 90;
	localparam int T_REC_NS      = 30;
	localparam int WE_LOW_CYC    = (T_WE_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int ACC_CYC       = (T_ACC_NS * CLK_MHZ + 999) / 1000;
	localparam int REC_CYC       = (T_REC_NS * CLK_MHZ + 999) / 1000;
	localparam int SYNC_CYC      = 2;
	// Typical block erase time; the poll timeout allows twice that
	localparam int ERASE_TIME_MS = 1600;
	localparam int POLL_LIMIT_CYC = 2 * ERASE_TIME_MS * CLK_MHZ * 1000;

	// Flash geometry: sixteen 64 KB blocks
	localparam int ADDR_W        = 20;
	localparam int BLOCK_LSB     = 16;

	// Device command codes
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_STAT  = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STAT = 8'h50;
	localparam logic [7:0] CMD_ERASE_SET  = 8'h20;
	localparam logic [7:0] CMD_CONFIRM    = 8'hD0;
	localparam logic [7:0] CMD_SUSPEND    = 8'hB0;
	localparam logic [7:0] CMD_PROG_SET   = 8'h40;

	// Device status bit positions
	localparam int SR_READY      = 7;
	localparam int SR_SUSP       = 6;
	localparam int SR_ERASE_ERR  = 5;
	localparam int SR_PROG_ERR   = 4;
	localparam int SR_SUPPLY_LOW = 3;

	// Host operation codes written to the command register
	localparam logic [2:0] OP_CLEAR  = 3'h1;
	localparam logic [2:0] OP_ERASE  = 3'h2;
	localparam logic [2:0] OP_PROG   = 3'h3;
	localparam logic [2:0] OP_SUSP   = 3'h4;
	localparam logic [2:0] OP_RESUME = 3'h5;
	localparam logic [2:0] OP_RDSTAT = 3'h6;
	localparam logic [2:0] OP_RDARR  = 3'h7;
	localparam int CMD_NOWAIT_BIT = 3;

	// APB register offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_CMD    = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_RDATA  = 8'h14;
	// Control fields and reset value
	localparam int CTRL_PD_BIT     = 0;
	localparam int CTRL_SUPPLY_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	// Status fields
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_REFUSED = 2;
	localparam int ST_TIMEOUT = 3;
	localparam int ST_RB = 4;
	localparam int ST_SUPPLY_SEEN = 5;
	localparam int ST_SUSPENDED = 6;
	localparam int ST_ERASING = 7;
	localparam int ST_SR_LSB = 8;
endpackage : fes_pkg

// file: fes_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module fes_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	// Asynchronous input and synchronised output
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_ff;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			meta_ff <= '0;
			sync_o  <= '0;
		end else begin
			meta_ff <= async_i;
			sync_o  <= meta_ff;
		end
	end
endmodule : fes_sync
`default_nettype wire

// file: fes_flash_cycle.sv
// One asynchronous flash bus cycle, read or write
`timescale 1ns/1ps
`default_nettype none
module fes_flash_cycle (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      sys_rst_i,
	// Cycle request
	input  wire logic                      start_i,
	input  wire logic                      read_i,
	input  wire logic [fes_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [7:0]                wdata_i,
	output logic                           done_o,
	output logic      [7:0]                rdata_o,
	// Flash pins, data input already synchronised
	input  wire logic [7:0]                dq_sync_i,
	output logic      [fes_pkg::ADDR_W-1:0] addr_o,
	output logic      [7:0]                dq_o,
	output logic                           dq_oe_o,
	output logic                           ce_n_o,
	output logic                           oe_n_o,
	output logic                           we_n_o
);
	import fes_pkg::*;

	typedef enum logic [2:0] {
		FC_IDLE = 3'b001,
		FC_ACT  = 3'b010,
		FC_REC  = 3'b100
	} fes_cyc_state_t;

	fes_cyc_state_t state_ff;
	logic [7:0]     cnt_ff;
	logic           read_ff;

	// Strobe sequencing; a read holds OE long enough to cover the synchroniser
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_ff <= FC_IDLE;
			cnt_ff   <= 8'h00;
			read_ff  <= 1'b0;
			done_o   <= 1'b0;
			ce_n_o   <= 1'b1;
			oe_n_o   <= 1'b1;
			we_n_o   <= 1'b1;
			dq_oe_o  <= 1'b0;
			dq_o     <= 8'h00;
			addr_o   <= '0;
			rdata_o  <= 8'h00;
		end else begin
			done_o <= 1'b0;
			case (state_ff)
				FC_IDLE: begin
					if (start_i) begin
						state_ff <= FC_ACT;
						read_ff  <= read_i;
						addr_o   <= addr_i;
						dq_o     <= wdata_i;
						dq_oe_o  <= !read_i;
						ce_n_o   <= 1'b0;
						oe_n_o   <= !read_i;
						we_n_o   <= read_i;
						cnt_ff   <= read_i ? 8'(ACC_CYC + SYNC_CYC) : 8'(WE_LOW_CYC);
					end
				end
				FC_ACT: begin
					if (cnt_ff <= 8'h01) begin
						// Rising WE latches address and data in the device
						state_ff <= FC_REC;
						ce_n_o   <= 1'b1;
						oe_n_o   <= 1'b1;
						we_n_o   <= 1'b1;
						cnt_ff   <= 8'(REC_CYC);
						if (read_ff) begin
							rdata_o <= dq_sync_i;
						end
					end else begin
						cnt_ff <= cnt_ff - 8'h01;
					end
				end
				FC_REC: begin
					// Data held past the strobe edge, then released
					if (cnt_ff <= 8'h01) begin
						state_ff <= FC_IDLE;
						dq_oe_o  <= 1'b0;
						done_o   <= 1'b1;
					end else begin
						cnt_ff <= cnt_ff - 8'h01;
					end
				end
				default: begin
					state_ff <= FC_IDLE;
				end
			endcase
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	property p_no_strobe_clash;
		!(!oe_n_o && !we_n_o) && !(!oe_n_o && dq_oe_o);
	endproperty
	a_no_strobe_clash: assert property (p_no_strobe_clash) else $error("OE and WE clash");

	property p_we_latch;
		$rose(we_n_o) |-> !$past(ce_n_o) && dq_oe_o;
	endproperty
	a_we_latch: assert property (p_we_latch) else $error("WE rose without data");
endmodule : fes_flash_cycle
`default_nettype wire

// file: fes_host_ctrl.sv
// APB-controlled host sequencer for a byte-wide command-driven flash
// Function
// - Op clear issues code 50H to reset the error and supply-low bits.
// - After supply-low is seen, refuse erase and program until status is cleared.
// - Erase issues 20H then D0H, both at an address in the block.
// - While suspended, only read array, read status and resume are issued.
// - Program issues setup 40H then address and data write.
// - FFH returns to array read, but not while the device is busy.
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fes_host_ctrl #(
	parameter int POLL_LIMIT = fes_pkg::POLL_LIMIT_CYC
) (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      sys_rst_i,
	// APB slave
	input  wire logic                      psel_i,
	input  wire logic                      penable_i,
	input  wire logic                      pwrite_i,
	input  wire logic [7:0]                paddr_i,
	input  wire logic [31:0]               pwdata_i,
	output logic      [31:0]               prdata_o,
	output logic                           pready_o,
	output logic                           pslverr_o,
	// Flash pins
	output logic      [fes_pkg::ADDR_W-1:0] flash_addr_o,
	output logic      [7:0]                flash_dq_o,
	output logic                           flash_dq_oe_o,
	input  wire logic [7:0]                flash_dq_i,
	output logic                           flash_ce_n_o,
	output logic                           flash_oe_n_o,
	output logic                           flash_we_n_o,
	output logic                           powerdown_reset_n_o,
	output logic                           program_supply_high_o,
	input  wire logic                      ready_busy_n_out_i
);
	import fes_pkg::*;

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_CMD1 = 5'b00010,
		S_CMD2 = 5'b00100,
		S_POLL = 5'b01000,
		S_READ = 5'b10000
	} fes_state_t;

	fes_state_t          state_ff;
	logic [1:0]          ctrl_ff;
	logic [ADDR_W-1:0]   addr_ff;
	logic [7:0]          wdata_ff;
	logic [2:0]          op_ff;
	logic [7:0]          cmd1_ff;
	logic [7:0]          cmd2_ff;
	logic                has_cmd2_ff;
	logic                poll_ff;
	logic                issued_ff;
	logic                cyc_start_ff;
	logic [31:0]         poll_cnt_ff;
	logic                done_ff;
	logic                refused_ff;
	logic                timeout_ff;
	logic                supply_seen_ff;
	logic                suspended_ff;
	logic                erasing_ff;
	logic [7:0]          last_sr_ff;
	logic [7:0]          rdata_ff;
	logic                pready_ff;
	logic                pslverr_ff;
	logic [31:0]         prdata_ff;

	logic [8:0]          sync_out;
	logic                rb_sync;
	logic [7:0]          dq_sync;
	logic                cyc_done;
	logic [7:0]          cyc_rdata;
	logic                cyc_read;
	logic [7:0]          cyc_wdata;
	logic                apb_wr;
	logic                cmd_wr;
	logic [2:0]          cmd_op;
	logic                allowed;
	logic                accept;
	logic                finish;
	logic                sr_seen;
	logic [31:0]         status_word;

	assign rb_sync = sync_out[8];
	assign dq_sync = sync_out[7:0];

	// Pin inputs pass the synchroniser before any logic reads them
	fes_sync #(
		.W (9)
	) u_sync (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.async_i   ({ready_busy_n_out_i, flash_dq_i}),
		.sync_o    (sync_out)
	);

	// Cycle engine drives every flash strobe from its own flops
	fes_flash_cycle u_cycle (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (cyc_start_ff),
		.read_i    (cyc_read),
		.addr_i    (addr_ff),
		.wdata_i   (cyc_wdata),
		.done_o    (cyc_done),
		.rdata_o   (cyc_rdata),
		.dq_sync_i (dq_sync),
		.addr_o    (flash_addr_o),
		.dq_o      (flash_dq_o),
		.dq_oe_o   (flash_dq_oe_o),
		.ce_n_o    (flash_ce_n_o),
		.oe_n_o    (flash_oe_n_o),
		.we_n_o    (flash_we_n_o)
	);

	// APB write commits only at the edge that completes the access
	assign apb_wr = psel_i && penable_i && pready_ff && pwrite_i;
	assign cmd_wr = apb_wr && (paddr_i == REG_CMD);
	assign cmd_op = pwdata_i[2:0];

	// Operation filter against the device's current mode
	always_comb begin
		allowed = 1'b0;
		if (suspended_ff) begin
			allowed = (cmd_op == OP_RDARR) || (cmd_op == OP_RDSTAT) ||
				(cmd_op == OP_RESUME);
		end else if (!rb_sync) begin
			// Busy device: status reads, and suspend of a running erase only
			allowed = (cmd_op == OP_RDSTAT) || (erasing_ff && cmd_op == OP_SUSP);
		end else begin
			case (cmd_op)
				OP_ERASE,
				OP_PROG:   allowed = !supply_seen_ff;
				OP_RESUME,
				OP_SUSP:   allowed = 1'b0;
				3'h0:      allowed = 1'b0;
				default:   allowed = 1'b1;
			endcase
		end
	end

	assign accept = cmd_wr && (state_ff == S_IDLE) && allowed && ctrl_ff[CTRL_PD_BIT] == 1'b0;
	assign cyc_read  = (state_ff == S_POLL) || (state_ff == S_READ);
	assign cyc_wdata = (state_ff == S_CMD2) ? cmd2_ff : cmd1_ff;
	assign finish = cyc_done && (
		(state_ff == S_READ) ||
		(state_ff == S_CMD1 && !has_cmd2_ff && !poll_ff && op_ff < OP_RDSTAT) ||
		(state_ff == S_CMD2 && !poll_ff) ||
		(state_ff == S_POLL && (cyc_rdata[SR_READY] || poll_cnt_ff >= POLL_LIMIT ||
			ctrl_ff[CTRL_PD_BIT])));
	// A read is status data in every mode but array read
	assign sr_seen = cyc_done && ((state_ff == S_POLL) ||
		(state_ff == S_READ && op_ff == OP_RDSTAT));

	// Command decode: one or two writes; erase, program and suspend poll unless no-wait is set, read status and read array add a read
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			op_ff       <= 3'h0;
			cmd1_ff     <= CMD_READ_ARRAY;
			cmd2_ff     <= CMD_CONFIRM;
			has_cmd2_ff <= 1'b0;
			poll_ff     <= 1'b0;
		end else if (accept) begin
			op_ff       <= cmd_op;
			has_cmd2_ff <= (cmd_op == OP_ERASE) || (cmd_op == OP_PROG);
			poll_ff     <= !pwdata_i[CMD_NOWAIT_BIT] && ((cmd_op == OP_ERASE) ||
				(cmd_op == OP_PROG) || (cmd_op == OP_SUSP));
			cmd2_ff     <= (cmd_op == OP_PROG) ? wdata_ff : CMD_CONFIRM;
			case (cmd_op)
				OP_CLEAR:  cmd1_ff <= CMD_CLEAR_STAT;
				OP_ERASE:  cmd1_ff <= CMD_ERASE_SET;
				OP_PROG:   cmd1_ff <= CMD_PROG_SET;
				OP_SUSP:   cmd1_ff <= CMD_SUSPEND;
				OP_RESUME: cmd1_ff <= CMD_CONFIRM;
				OP_RDSTAT: cmd1_ff <= CMD_READ_STAT;
				default:   cmd1_ff <= CMD_READ_ARRAY;
			endcase
		end
	end

	// Sequencer; each step launches one bus cycle and moves on when it ends, except poll, which reads again until finish
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_ff     <= S_IDLE;
			issued_ff    <= 1'b0;
			cyc_start_ff <= 1'b0;
		end else begin
			cyc_start_ff <= 1'b0;
			if (state_ff != S_IDLE && !issued_ff && !finish) begin
				cyc_start_ff <= 1'b1;
				issued_ff    <= 1'b1;
			end
			if (cyc_done) begin
				issued_ff <= 1'b0;
			end
			case (state_ff)
				S_IDLE: if (accept) state_ff <= S_CMD1;
				S_CMD1: begin
					if (finish) begin
						state_ff <= S_IDLE;
					end else if (cyc_done) begin
						state_ff <= has_cmd2_ff ? S_CMD2 : (poll_ff ? S_POLL : S_READ);
					end
				end
				S_CMD2: if (cyc_done) state_ff <= finish ? S_IDLE : S_POLL;
				S_POLL: if (finish) state_ff <= S_IDLE;
				S_READ: if (finish) state_ff <= S_IDLE;
				default: state_ff <= S_IDLE;
			endcase
		end
	end

	// Poll watchdog, long enough for a full block erase
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || state_ff != S_POLL) begin
			poll_cnt_ff <= 32'h0000_0000;
		end else if (poll_cnt_ff < POLL_LIMIT) begin
			poll_cnt_ff <= poll_cnt_ff + 32'h0000_0001;
		end
	end

	// Device mode tracking from captured status and issued commands
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || ctrl_ff[CTRL_PD_BIT]) begin
			// Powerdown resets the device status, so host copies follow
			last_sr_ff     <= 8'h80;
			supply_seen_ff <= 1'b0;
			suspended_ff   <= 1'b0;
			erasing_ff     <= 1'b0;
		end else begin
			if (accept && cmd_op == OP_ERASE) begin
				erasing_ff <= 1'b1;
			end
			if (accept && cmd_op == OP_RESUME) begin
				suspended_ff <= 1'b0;
			end
			if (finish && op_ff == OP_CLEAR) begin
				supply_seen_ff <= 1'b0;
				last_sr_ff     <= last_sr_ff & 8'hC7;
			end
			if (sr_seen) begin
				last_sr_ff <= cyc_rdata;
				if (cyc_rdata[SR_SUPPLY_LOW]) begin
					supply_seen_ff <= 1'b1;
				end
				if (cyc_rdata[SR_READY]) begin
					suspended_ff <= cyc_rdata[SR_SUSP];
					erasing_ff   <= erasing_ff && cyc_rdata[SR_SUSP];
				end
			end
		end
	end

	// Sticky result flags: a new event wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			done_ff    <= 1'b0;
			refused_ff <= 1'b0;
			timeout_ff <= 1'b0;
			rdata_ff   <= 8'h00;
		end else begin
			if (apb_wr && paddr_i == REG_STATUS) begin
				done_ff    <= done_ff & !pwdata_i[ST_DONE];
				refused_ff <= refused_ff & !pwdata_i[ST_REFUSED];
				timeout_ff <= timeout_ff & !pwdata_i[ST_TIMEOUT];
			end
			if (finish) begin
				done_ff <= 1'b1;
			end
			if (cmd_wr && !accept) begin
				refused_ff <= 1'b1;
			end
			// Powerdown ends the poll on garbage data, so it always flags an abort
			if (finish && state_ff == S_POLL &&
				!(cyc_rdata[SR_READY] && !ctrl_ff[CTRL_PD_BIT])) begin
				timeout_ff <= 1'b1;
			end
			if (cyc_done && state_ff == S_READ) begin
				rdata_ff <= cyc_rdata;
			end
		end
	end

	// Software-held pin levels and operand registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ctrl_ff  <= CTRL_RESET;
			addr_ff  <= '0;
			wdata_ff <= 8'h00;
		end else if (apb_wr) begin
			case (paddr_i)
				REG_CTRL:  ctrl_ff  <= pwdata_i[1:0];
				REG_ADDR:  addr_ff  <= pwdata_i[ADDR_W-1:0];
				REG_WDATA: wdata_ff <= pwdata_i[7:0];
				default:   ctrl_ff  <= ctrl_ff;
			endcase
		end
	end

	// Pins straight from flops
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			powerdown_reset_n_o   <= 1'b1;
			program_supply_high_o <= 1'b0;
		end else begin
			powerdown_reset_n_o   <= !ctrl_ff[CTRL_PD_BIT];
			program_supply_high_o <= ctrl_ff[CTRL_SUPPLY_BIT];
		end
	end

	assign status_word = {16'h0000, last_sr_ff, erasing_ff, suspended_ff, supply_seen_ff,
		rb_sync, timeout_ff, refused_ff, done_ff, state_ff != S_IDLE};

	// APB answer: one wait state, so read data comes from a flop
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= psel_i && penable_i && !pready_ff;
			pslverr_ff <= 1'b0;
			if (psel_i && penable_i && !pready_ff) begin
				pslverr_ff <= paddr_i > REG_RDATA || paddr_i[1:0] != 2'h0;
				case (paddr_i)
					REG_CTRL:   prdata_ff <= {30'h0000_0000, ctrl_ff};
					REG_ADDR:   prdata_ff <= {12'h000, addr_ff};
					REG_WDATA:  prdata_ff <= {24'h00_0000, wdata_ff};
					REG_STATUS: prdata_ff <= status_word;
					REG_RDATA:  prdata_ff <= {24'h00_0000, rdata_ff};
					default:    prdata_ff <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign prdata_o  = prdata_ff;
	assign pready_o  = pready_ff;
	assign pslverr_o = pslverr_ff;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	property p_clear_code;
		accept && cmd_op == OP_CLEAR |=> cmd1_ff == 8'h50 && !has_cmd2_ff;
	endproperty
	a_clear_code: assert property (p_clear_code) else $error("Clear not 50H");

	property p_supply_block;
		cmd_wr && supply_seen_ff && (cmd_op == OP_ERASE || cmd_op == OP_PROG) |-> !accept;
	endproperty
	a_supply_block: assert property (p_supply_block) else $error("Op after supply low");

	sequence s_erase_second;
		state_ff == S_CMD2 && op_ff == OP_ERASE;
	endsequence
	property p_erase_pair;
		s_erase_second |-> cmd1_ff == 8'h20 && cmd2_ff == 8'hD0;
	endproperty
	a_erase_pair: assert property (p_erase_pair) else $error("Erase pair wrong");

	property p_prog_setup;
		accept && cmd_op == OP_PROG |=> cmd1_ff == 8'h40 ##1 state_ff == S_CMD1;
	endproperty
	a_prog_setup: assert property (p_prog_setup) else $error("Program setup wrong");

	property p_suspend_filter;
		accept && suspended_ff |-> cmd_op == OP_RDARR || cmd_op == OP_RDSTAT ||
			cmd_op == OP_RESUME;
	endproperty
	a_suspend_filter: assert property (p_suspend_filter) else $error("Bad op in suspend");

	property p_rdarr_ready;
		accept && cmd_op == OP_RDARR |-> rb_sync && !suspended_ff || suspended_ff;
	endproperty
	a_rdarr_ready: assert property (p_rdarr_ready) else $error("Array read while busy");

	property p_poll_end;
		state_ff == S_POLL && cyc_done && cyc_rdata[7] |=> state_ff == S_IDLE && done_ff;
	endproperty
	a_poll_end: assert property (p_poll_end) else $error("Poll did not end");

	sequence s_apb_wait;
		psel_i && penable_i && !pready_ff;
	endsequence
	property p_apb_one_wait;
		s_apb_wait |=> pready_ff ##1 !pready_ff;
	endproperty
	a_apb_one_wait: assert property (p_apb_one_wait) else $error("APB wait not one cycle");
endmodule : fes_host_ctrl
`default_nettype wire

// file: fes_flash_model.sv
// Behavioural flash device on the far side of the host controller
`timescale 1ns/1ps
`default_nettype none
module fes_flash_model #(
	parameter int ERASE_CYC = 400,
	parameter int PROG_CYC  = 30
) (
	// Timer clock and device pins
	input  wire logic        clk_i,
	input  wire logic [19:0] addr_i,
	input  wire logic [7:0]  dq_i,
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic        powerdown_reset_n_i,
	input  wire logic        program_supply_high_i,
	// Read data and ready/busy
	output logic      [7:0]  dq_o,
	output logic             ready_busy_n_out_o
);
	// Only offsets 0-15 of each block are kept, enough for the bench
	logic [7:0] mem [256];
	logic [4:0] sr = 5'h10; // Ready, suspended, erase err, prog err, supply low
	logic [7:0] pa, pd, tog = 8'h00;
	logic [1:0] pend = 2'd0, pp;
	logic       stat = 1'b0, sreq = 1'b0, ers = 1'b0, pwe = 1'b1, pce = 1'b1;
	int         cnt = 0;
	wire  [7:0] ix = {addr_i[19:16], addr_i[3:0]};
	initial foreach (mem[i]) mem[i] = 8'hFF;
	// Released bus toggles so a stale value cannot pass for data
	assign dq_o = (!ce_n_i && !oe_n_i && powerdown_reset_n_i) ?
		(stat ? {sr, 3'h0} : mem[ix]) : tog;
	assign ready_busy_n_out_o = sr[4];
	// Timers, aborts and command writes, all seen on the clock
	always @(posedge clk_i) begin
		tog <= ~tog;
		pp = pend;
		if (!powerdown_reset_n_i) begin
			sr = 5'h10;
			{stat, pend, cnt} = '0;
		end else if (cnt > 0 && !sr[3] && !program_supply_high_i) begin
			cnt = 0;
			sr = sr | 5'h11;
		end else if (cnt > 0 && !sr[3]) begin
			if (sreq) sr[4:3] = 2'b11;
			else cnt--;
			if (cnt == 0 && ers) for (int i = 0; i < 16; i++) mem[{pa[7:4], 4'(i)}] = 8'hFF;
			else if (cnt == 0) mem[pa] &= pd;
			sr[4] = sr[4] | (cnt == 0);
		end
		// Data and address are latched as the write strobe rises
		if (!pwe && !pce && we_n_i && powerdown_reset_n_i) begin
			pend = 2'd0;
			stat = stat | (pp != 2'd0);
			if (pp == 2'd1 && dq_i != 8'hD0) sr[2:1] = 2'b11;
			else if (pp != 2'd0 && (!program_supply_high_i || sr[0])) sr[0] = 1'b1;
			else if (pp != 2'd0) begin
				ers = pp[0];
				{pa, pd, sr[4]} = {ix, dq_i, 1'b0};
				cnt = ers ? ERASE_CYC : PROG_CYC;
			end else if (cnt > 0 && !sr[3]) begin
				stat = stat | (dq_i == 8'h70);
				sreq = sreq | (ers && dq_i == 8'hB0);
			end else if (sr[3]) begin
				stat = (dq_i == 8'hFF) ? 1'b0 : stat | (dq_i == 8'h70) | (dq_i == 8'hD0);
				if (dq_i == 8'hD0) {sr[4:3], sreq} = 3'b000;
			end else begin
				stat = (dq_i == 8'hFF) ? 1'b0 : stat | (dq_i == 8'h70);
				sr[2:0] = (dq_i == 8'h50) ? 3'h0 : sr[2:0];
				pend = (dq_i == 8'h20) ? 2'd1 : (dq_i == 8'h40 || dq_i == 8'h10) ? 2'd2 : 2'd0;
			end
		end
		{pwe, pce} = {we_n_i, ce_n_i};
	end
endmodule : fes_flash_model
`default_nettype wire

// file: tb_top.sv
// Random and directed bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] %s expected %0h seen %0h", n, e, g); end end
module tb_top;
	import fes_pkg::*;
	localparam logic [2:0] NOPE [5] = '{OP_CLEAR, OP_ERASE, OP_PROG, OP_RESUME, OP_RDARR};
	logic        clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
	logic [7:0]  paddr_i, flash_dq_o, flash_dq_i, dev_dq, expm [256];
	logic [31:0] pwdata_i, prdata_o, rd, st;
	logic [19:0] flash_addr_o, adr [4];
	logic        flash_dq_oe_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o;
	logic        powerdown_reset_n_o, program_supply_high_o, ready_busy_n_out_i;
	int          bad_count = 0, samples_checked = 0;
	// Level of the shared data pins
	assign flash_dq_i = flash_dq_oe_o ? flash_dq_o : dev_dq;
	fes_host_ctrl #(.POLL_LIMIT(20000)) fes_host_ctrl_inst (.clk_i, .sys_rst_i, .psel_i,
		.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
		.flash_addr_o, .flash_dq_o, .flash_dq_oe_o, .flash_dq_i, .flash_ce_n_o, .flash_oe_n_o,
		.flash_we_n_o, .powerdown_reset_n_o, .program_supply_high_o, .ready_busy_n_out_i);
	fes_flash_model fes_flash_model_inst (.clk_i, .addr_i(flash_addr_o), .dq_i(flash_dq_i),
		.ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o),
		.powerdown_reset_n_i(powerdown_reset_n_o), .program_supply_high_i(program_supply_high_o),
		.dq_o(dev_dq), .ready_busy_n_out_o(ready_busy_n_out_i));
	// 250 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// Watchdog well above the expected run length
	initial begin
		#400000;
		bad_count++;
		close_out();
	end
	task automatic close_out();
		$display("Checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out
	// One APB transfer; data and error taken at the completing edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i) n++; while (pready_o !== 1'b1 && n < 200);
		if (pready_o !== 1'b1) bad_count++;
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	// Poll until idle, then clear the sticky flags
	task automatic op(input logic [3:0] c);
		int n = 0;
		apb(1'b1, REG_CMD, {28'h0, c});
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (rd[ST_BUSY] !== 1'b0 && n < 3000);
		if (rd[ST_BUSY] !== 1'b0) bad_count++;
		st = rd;
		apb(1'b1, REG_STATUS, 32'hE);
	endtask : op
	task automatic chk_arr();
		foreach (adr[i]) begin
			apb(1'b1, REG_ADDR, {12'h0, adr[i]});
			op({1'b0, OP_RDARR});
			apb(1'b0, REG_RDATA, 32'h0);
			`CHK("array", expm[{adr[i][19:16], adr[i][3:0]}], rd[7:0])
		end
	endtask : chk_arr
	initial begin
		logic [7:0] d;
		void'($urandom(50512));
		sys_rst_i = 1'b1;
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		foreach (expm[i]) expm[i] = 8'hFF;
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		`CHK("pd pin", 1'b1, powerdown_reset_n_o)
		apb(1'b0, 8'h18, 32'h0);
		`CHK("slverr", 1'b1, err)
		// Program at low supply, then erase refused until cleared
		apb(1'b1, REG_ADDR, 32'h10);
		op({1'b0, OP_PROG});
		`CHK("sr", 8'h88, st[15:8])
		op({1'b0, OP_ERASE});
		`CHK("refused", 1'b1, st[ST_REFUSED])
		op({1'b0, OP_CLEAR});
		op({1'b0, OP_RDSTAT});
		`CHK("sr", 8'h80, st[15:8])
		// Random programs; two land on bytes already written
		apb(1'b1, REG_CTRL, 32'h2);
		foreach (adr[i]) adr[i] = {4'($urandom_range(15)), 12'h0, 4'(i)};
		for (int i = 0; i < 6; i++) begin
			d = 8'($urandom);
			apb(1'b1, REG_ADDR, {12'h0, adr[i % 4]});
			apb(1'b1, REG_WDATA, {24'h0, d});
			op({1'b0, OP_PROG});
			expm[{adr[i % 4][19:16], adr[i % 4][3:0]}] &= d;
			`CHK("sr", 8'h80, st[15:8])
		end
		chk_arr();
		// Erase without polling, refusals, suspend and resume
		apb(1'b1, REG_ADDR, {12'h0, adr[0]});
		op(4'h8 | {1'b0, OP_ERASE});
		foreach (NOPE[i]) begin
			op({1'b0, NOPE[i]});
			`CHK("refused", 1'b1, st[ST_REFUSED])
		end
		op({1'b0, OP_SUSP});
		`CHK("sr", 2'b11, st[15:14])
		`CHK("rb", 1'b1, st[ST_RB])
		op({1'b0, OP_PROG});
		`CHK("refused", 1'b1, st[ST_REFUSED])
		op({1'b0, OP_RESUME});
		// Resume writes no poll, so read status while the erase runs on
		op({1'b0, OP_RDSTAT});
		`CHK("sr", 8'h00, st[15:8])
		`CHK("rb", 1'b0, st[ST_RB])
		repeat (400) @(posedge clk_i);
		op({1'b0, OP_RDSTAT});
		`CHK("sr", 8'h80, st[15:8])
		foreach (expm[i]) if ((i >> 4) == adr[0][19:16]) expm[i] = 8'hFF;
		chk_arr();
		// Powerdown in the middle of a polled erase
		apb(1'b1, REG_ADDR, {12'h0, adr[1]});
		apb(1'b1, REG_CMD, {29'h0, OP_ERASE});
		repeat (100) @(posedge clk_i);
		apb(1'b1, REG_CTRL, 32'h3);
		op({1'b0, OP_RDSTAT});
		`CHK("pd pin", 1'b0, powerdown_reset_n_o)
		`CHK("abort", 1'b1, st[ST_TIMEOUT])
		apb(1'b1, REG_CTRL, 32'h2);
		repeat (4) @(posedge clk_i);
		op({1'b0, OP_RDSTAT});
		`CHK("sr", 8'h80, st[15:8])
		close_out();
	end
endmodule : tb_top
`default_nettype wire
